// file: atbc_ctrl.sv
// Functional notes
// - Level register reports six-bit count of valid buffer entries.
// - No transmit DMA request unless transmit DMA enable is one.
// - Writing one to user-data clear clears its pending interrupt.
// - Writing one to transfer-end clear clears its pending interrupt.
// - Five-bit writable threshold sets the buffer-empty fill level.
// - Buffer-empty interrupt forwarded only when its enable is one.
// - Transfer-end interrupt raised at block end (linear PCM) or repetition period end (non-linear PCM).
// - User-data interrupt raised when user data copied to shadow.
// - Buffer-empty status bit reads one when condition active.
// - Transfer-end status bit reads one when condition active.
// - User-data status bit reads one when condition active.
//
// Purpose: buffer level, DMA request and interrupt control for audio tx
// Assumes: APB slave, zero wait states, single pclk domain
// Notes: event inputs are one-cycle pulses from logic on pclk
//
// Local design decision: register access over APB.
`timescale 1ns/1ns
module atbc_ctrl
    import atbc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ATBC_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ATBC_CNT_W-1:0] buffer_fill_count,
    input wire logic nonlinear_pcm,
    input wire logic block_done,
    input wire logic repetition_done,
    input wire logic user_data_shadowed,
    output logic dma_tx_req,
    output logic irq
);

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic wr_en;
    logic rd_en;
    logic hit_level;
    logic hit_dma;
    logic hit_ictl;
    logic hit_istat;
    logic addr_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign hit_level = (paddr == ATBC_OFF_LEVEL);
    assign hit_dma = (paddr == ATBC_OFF_DMA);
    assign hit_ictl = (paddr == ATBC_OFF_ICTL);
    assign hit_istat = (paddr == ATBC_OFF_ISTAT);
    assign addr_ok = hit_level || hit_dma || hit_ictl || hit_istat;
    // Always ready; unmapped addresses answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic tx_dma_enable_q;
    logic [ATBC_LVL_W-1:0] tx_dma_watermark_q;
    logic [ATBC_LVL_W-1:0] buffer_empty_threshold_q;
    atbc_irq_en_t irq_en_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_dma_enable_q <= 1'b0;
            tx_dma_watermark_q <= ATBC_LVL_RST;
        end
        else if (wr_en && hit_dma && pstrb[0])
        begin
            tx_dma_enable_q <= pwdata[ATBC_DMA_EN_BIT];
            tx_dma_watermark_q <= pwdata[ATBC_DMA_WM_LSB +: ATBC_LVL_W];
        end
    end

    // Threshold straddles byte lanes 0 and 1; both needed for a clean update
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            buffer_empty_threshold_q <= ATBC_LVL_RST;
            irq_en_q <= '0;
        end
        else if (wr_en && hit_ictl)
        begin
            if (pstrb[0])
            begin
                irq_en_q.buffer_empty_irq_enable <= pwdata[ATBC_BE_BIT];
                irq_en_q.transfer_end_irq_enable <= pwdata[ATBC_TE_BIT];
                irq_en_q.user_data_irq_enable <= pwdata[ATBC_UD_BIT];
            end
            if (pstrb[0] && pstrb[1])
            begin
                buffer_empty_threshold_q <= pwdata[ATBC_THR_LSB +: ATBC_LVL_W];
            end
        end
    end

    // ------------------------------------------------------------
    // Level comparisons
    // ------------------------------------------------------------
    logic below_watermark;
    logic below_threshold;

    atbc_level_cmp u_wm_cmp
    (
        .pclk(pclk),
        .presetn(presetn),
        .count(buffer_fill_count),
        .level(tx_dma_watermark_q),
        .at_or_below(below_watermark)
    );

    atbc_level_cmp u_thr_cmp
    (
        .pclk(pclk),
        .presetn(presetn),
        .count(buffer_fill_count),
        .level(buffer_empty_threshold_q),
        .at_or_below(below_threshold)
    );

    assign dma_tx_req = tx_dma_enable_q && below_watermark;

    // ------------------------------------------------------------
    // Interrupt status
    // ------------------------------------------------------------
    atbc_irq_st_t irq_st;
    logic te_event;
    logic te_clr;
    logic ud_clr;

    // block end for linear PCM, repetition end otherwise
    assign te_event = nonlinear_pcm ? repetition_done : block_done;
    assign te_clr = wr_en && hit_ictl && pstrb[2] && pwdata[ATBC_TE_CLR_BIT];
    assign ud_clr = wr_en && hit_ictl && pstrb[2] && pwdata[ATBC_UD_CLR_BIT];

    // level status follows the registered threshold compare, one cycle behind the buffer
    assign irq_st.buffer_empty_irq_status = below_threshold;

    atbc_event_flag u_te_flag
    (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(te_event),
        .clr_pulse(te_clr),
        .flag_q(irq_st.transfer_end_irq_status)
    );

    atbc_event_flag u_ud_flag
    (
        .pclk(pclk),
        .presetn(presetn),
        .set_pulse(user_data_shadowed),
        .clr_pulse(ud_clr),
        .flag_q(irq_st.user_data_irq_status)
    );

    // combine enabled sources, each source gated by its own enable
    assign irq = (irq_st.buffer_empty_irq_status && irq_en_q.buffer_empty_irq_enable)
        || (irq_st.transfer_end_irq_status && irq_en_q.transfer_end_irq_enable)
        || (irq_st.user_data_irq_status && irq_en_q.user_data_irq_enable);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [31:0] rdata_d;

    always_comb
    begin
        rdata_d = ATBC_ZERO;
        if (hit_level)
        begin
            rdata_d[ATBC_CNT_W-1:0] = buffer_fill_count;
        end
        else if (hit_dma)
        begin
            rdata_d[ATBC_DMA_EN_BIT] = tx_dma_enable_q;
            rdata_d[ATBC_DMA_WM_LSB +: ATBC_LVL_W] = tx_dma_watermark_q;
        end
        else if (hit_ictl)
        begin
            rdata_d[ATBC_THR_LSB +: ATBC_LVL_W] = buffer_empty_threshold_q;
            rdata_d[ATBC_BE_BIT] = irq_en_q.buffer_empty_irq_enable;
            rdata_d[ATBC_TE_BIT] = irq_en_q.transfer_end_irq_enable;
            rdata_d[ATBC_UD_BIT] = irq_en_q.user_data_irq_enable;
        end
        else if (hit_istat)
        begin
            rdata_d[ATBC_BE_BIT] = irq_st.buffer_empty_irq_status;
            rdata_d[ATBC_TE_BIT] = irq_st.transfer_end_irq_status;
            rdata_d[ATBC_UD_BIT] = irq_st.user_data_irq_status;
        end
    end

    // Read data held in a flop, loaded in setup so it is valid in access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= ATBC_ZERO;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // no request while disabled
    chk_dma_gated: assert property (@(posedge pclk) disable iff (!presetn)
        !tx_dma_enable_q |-> !dma_tx_req)
        else $error("dma request while disabled");

    // request tracks watermark one cycle later
    chk_dma_level: assert property (@(posedge pclk) disable iff (!presetn)
        (tx_dma_enable_q && $stable(tx_dma_enable_q) && !(wr_en && hit_dma)
        && (buffer_fill_count <= {1'b0, tx_dma_watermark_q})
        && $stable(tx_dma_watermark_q)) |=> dma_tx_req)
        else $error("dma request missing at watermark");

    chk_dma_above: assert property (@(posedge pclk) disable iff (!presetn)
        (buffer_fill_count > {1'b0, tx_dma_watermark_q}) |=> !dma_tx_req)
        else $error("dma request above watermark");

    // lane 0 off leaves dma control alone
    chk_dma_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_dma && !pstrb[0])
        |=> ($stable(tx_dma_enable_q) && $stable(tx_dma_watermark_q)))
        else $error("dma control changed without lane 0");

    chk_empty_thr: assert property (@(posedge pclk) disable iff (!presetn)
        ((buffer_fill_count > {1'b0, buffer_empty_threshold_q})
        && $stable(buffer_empty_threshold_q))
        |=> !irq_st.buffer_empty_irq_status)
        else $error("empty status above threshold");

    // empty status set at or below threshold
    chk_empty_set: assert property (@(posedge pclk) disable iff (!presetn)
        (buffer_fill_count <= {1'b0, buffer_empty_threshold_q})
        |=> irq_st.buffer_empty_irq_status)
        else $error("empty status missing at threshold");

    chk_thr_keep: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_ictl && !pstrb[1]) |=> $stable(buffer_empty_threshold_q))
        else $error("threshold changed without lane 1");

    // level read returns the live count
    chk_level_read: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && hit_level)
        |=> (prdata[ATBC_CNT_W-1:0] == $past(buffer_fill_count)))
        else $error("level read does not match count");

    chk_ud_set: assert property (@(posedge pclk) disable iff (!presetn)
        user_data_shadowed |=> irq_st.user_data_irq_status)
        else $error("user data status not set");

    chk_ud_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (ud_clr && !user_data_shadowed) |=> !irq_st.user_data_irq_status)
        else $error("user data status not cleared");

    chk_ud_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_st.user_data_irq_status && !ud_clr)
        |=> irq_st.user_data_irq_status)
        else $error("user data status dropped");

    chk_ud_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!irq_st.user_data_irq_status && !user_data_shadowed)
        |=> !irq_st.user_data_irq_status)
        else $error("user data status set without event");

    // transfer-end source chosen by pcm type
    chk_te_set: assert property (@(posedge pclk) disable iff (!presetn)
        ((nonlinear_pcm && repetition_done) || (!nonlinear_pcm && block_done))
        |=> irq_st.transfer_end_irq_status)
        else $error("transfer end status not set");

    chk_te_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (te_clr && !te_event) |=> !irq_st.transfer_end_irq_status)
        else $error("transfer end status not cleared");

    chk_te_hold: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_st.transfer_end_irq_status && !te_clr)
        |=> irq_st.transfer_end_irq_status)
        else $error("transfer end status dropped");

    chk_te_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        (!irq_st.transfer_end_irq_status && !te_event)
        |=> !irq_st.transfer_end_irq_status)
        else $error("transfer end status set without event");

    chk_irq_out: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_st.transfer_end_irq_status && irq_en_q.transfer_end_irq_enable) |-> irq)
        else $error("interrupt not asserted");

    chk_irq_ud: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_st.user_data_irq_status && irq_en_q.user_data_irq_enable) |-> irq)
        else $error("user data interrupt not asserted");

    chk_irq_be: assert property (@(posedge pclk) disable iff (!presetn)
        (irq_st.buffer_empty_irq_status && irq_en_q.buffer_empty_irq_enable) |-> irq)
        else $error("empty interrupt not asserted");

    // disabled empty source alone gives no interrupt
    chk_be_mask: assert property (@(posedge pclk) disable iff (!presetn)
        (!irq_en_q.buffer_empty_irq_enable && !irq_st.transfer_end_irq_status
        && !irq_st.user_data_irq_status) |-> !irq)
        else $error("masked empty source raised interrupt");

endmodule

// file: atbc_event_flag.sv
// Purpose: sticky status flag, set by an event pulse, cleared by write-one
// Assumes: event and clear both synchronous to pclk
// Notes: set wins over a clear arriving in the same cycle
`timescale 1ns/1ns
module atbc_event_flag
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic flag_q
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flag_q <= 1'b0;
        end
        else if (set_pulse)
        begin
            flag_q <= 1'b1;
        end
        else if (clr_pulse)
        begin
            flag_q <= 1'b0;
        end
    end
endmodule

// file: atbc_far_model.sv
// Purpose: far-side model: sample buffer source, dma answer, event pulses
// Assumes: one pclk domain, stimulus on rising edge
// Notes: dma answer spaced by gaps so the registered request can settle
`timescale 1ns/1ns
module atbc_far_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dma_tx_req,
    output logic [5:0] buffer_fill_count,
    output logic block_done,
    output logic repetition_done,
    output logic user_data_shadowed
);
    logic fill_en;
    logic [1:0] gap_q;

    initial
    begin
        fill_en = 1'b0;
        gap_q = 2'h0;
        buffer_fill_count = 6'h00;
        block_done = 1'b0;
        repetition_done = 1'b0;
        user_data_shadowed = 1'b0;
    end

    // One entry per request, then a pause; request lags the count
    always @(posedge pclk)
    begin
        if (gap_q != 2'h0)
            gap_q <= gap_q - 2'h1;
        else if (fill_en && presetn && dma_tx_req === 1'b1)
        begin
            buffer_fill_count <= buffer_fill_count + 6'h01;
            gap_q <= 2'h3;
        end
    end

    task automatic set_count(input logic [5:0] n);
        @(posedge pclk);
        buffer_fill_count <= n;
    endtask

    task automatic pulse(input logic [1:0] k);
        @(posedge pclk);
        block_done <= (k == 2'h0);
        repetition_done <= (k == 2'h1);
        user_data_shadowed <= (k == 2'h2);
        @(posedge pclk);
        block_done <= 1'b0;
        repetition_done <= 1'b0;
        user_data_shadowed <= 1'b0;
    endtask
endmodule

// file: atbc_level_cmp.sv
// Purpose: compare buffer fill count against a programmed level
// Assumes: same clock as the caller
// Notes: registered output, one cycle after the count changes
`timescale 1ns/1ns
module atbc_level_cmp
    import atbc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ATBC_CNT_W-1:0] count,
    input wire logic [ATBC_LVL_W-1:0] level,
    output logic at_or_below
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            at_or_below <= 1'b0;
        end
        else
        begin
            at_or_below <= (count <= {1'b0, level});
        end
    end
endmodule

// file: atbc_pkg.sv
// Purpose: shared constants and types for the audio tx buffer control block
// Assumes: APB, 32-bit data, byte addresses as printed
// Notes: field positions and offsets named once here
package atbc_pkg;

    localparam int ATBC_AW = 12;
    localparam logic [ATBC_AW-1:0] ATBC_OFF_LEVEL = 12'h004;
    localparam logic [ATBC_AW-1:0] ATBC_OFF_DMA = 12'h008;
    localparam logic [ATBC_AW-1:0] ATBC_OFF_ICTL = 12'h00C;
    localparam logic [ATBC_AW-1:0] ATBC_OFF_ISTAT = 12'h010;

    localparam int ATBC_CNT_W = 6;
    localparam int ATBC_LVL_W = 5;

    // DMA control fields
    localparam int ATBC_DMA_EN_BIT = 5;
    localparam int ATBC_DMA_WM_LSB = 0;

    // Interrupt control fields
    localparam int ATBC_UD_CLR_BIT = 17;
    localparam int ATBC_TE_CLR_BIT = 16;
    localparam int ATBC_THR_LSB = 5;

    // Enable and status bit positions, shared by both registers
    localparam int ATBC_BE_BIT = 4;
    localparam int ATBC_TE_BIT = 3;
    localparam int ATBC_UD_BIT = 2;

    localparam logic [ATBC_LVL_W-1:0] ATBC_LVL_RST = 5'h00;
    localparam logic [31:0] ATBC_ZERO = 32'h00000000;

    typedef struct packed {
        logic buffer_empty_irq_enable;
        logic transfer_end_irq_enable;
        logic user_data_irq_enable;
    } atbc_irq_en_t;

    typedef struct packed {
        logic buffer_empty_irq_status;
        logic transfer_end_irq_status;
        logic user_data_irq_status;
    } atbc_irq_st_t;

endpackage

// file: tb_atbc_ctrl.sv
// Purpose: self-checking bench for the audio tx buffer control block
// Assumes: APB master on pclk, far-side model drives the buffer side
// Notes: expectations worked from field positions, not from the design
`timescale 1ns/1ns
module tb_atbc_ctrl
    import atbc_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ATBC_AW-1:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] cnt;
    logic nonlinear_pcm;
    logic bd, rd, ud, dma_tx_req, irq;
    logic [31:0] rv;
    logic ev;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;

    always #25 pclk = ~pclk;

    atbc_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .buffer_fill_count(cnt),
        .nonlinear_pcm(nonlinear_pcm), .block_done(bd), .repetition_done(rd),
        .user_data_shadowed(ud), .dma_tx_req(dma_tx_req), .irq(irq));

    atbc_far_model far (.pclk(pclk), .presetn(presetn), .dma_tx_req(dma_tx_req),
        .buffer_fill_count(cnt), .block_done(bd), .repetition_done(rd),
        .user_data_shadowed(ud));

    task automatic give_verdict();
        if (n_fail == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(rv, exp);
        chk({31'h0, ev}, 32'h00000000);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Output is read after the wait, never captured at call time
    task automatic sig_irq(input logic exp);
        idle(3);
        chk({31'h0, irq}, {31'h0, exp});
    endtask

    task automatic sig_req(input logic exp);
        idle(3);
        chk({31'h0, dma_tx_req}, {31'h0, exp});
    endtask

    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = ATBC_OFF_LEVEL;
        pwdata = ATBC_ZERO;
        pstrb = 4'hF;
        nonlinear_pcm = 1'b0;
        idle(4);
        presetn <= 1'b1;
        rd_chk(ATBC_OFF_DMA, 32'h00000000);
        rd_chk(ATBC_OFF_ICTL, 32'h00000000);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000010);
        sig_irq(1'b0);
        far.set_count(6'h3F);
        apb(1'b1, ATBC_OFF_LEVEL, 32'h00000000);
        rd_chk(ATBC_OFF_LEVEL, 32'h0000003F);
        // ---------------------------------
        // DMA request gating and watermark
        // ---------------------------------
        far.set_count(6'h00);
        apb(1'b1, ATBC_OFF_DMA, 32'h0000001F);
        sig_req(1'b0);
        apb(1'b1, ATBC_OFF_DMA, 32'h0000002A);
        rd_chk(ATBC_OFF_DMA, 32'h0000002A);
        sig_req(1'b1);
        pstrb <= 4'hE;
        apb(1'b1, ATBC_OFF_DMA, 32'h00000000);
        pstrb <= 4'hF;
        rd_chk(ATBC_OFF_DMA, 32'h0000002A);
        far.set_count(6'h0A);
        sig_req(1'b1);
        far.set_count(6'h0B);
        sig_req(1'b0);
        far.set_count(6'h00);
        far.fill_en <= 1'b1;
        idle(80);
        far.fill_en <= 1'b0;
        chk({26'h0, cnt}, 32'h0000000B);
        rd_chk(ATBC_OFF_LEVEL, 32'h0000000B);
        apb(1'b1, ATBC_OFF_DMA, 32'h0000000A);
        far.set_count(6'h00);
        sig_req(1'b0);
        // ---------------------------------
        // Buffer-empty threshold
        // ---------------------------------
        apb(1'b1, ATBC_OFF_ICTL, 32'h000000B0);
        rd_chk(ATBC_OFF_ICTL, 32'h000000B0);
        far.set_count(6'h05);
        sig_irq(1'b1);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000010);
        far.set_count(6'h06);
        sig_irq(1'b0);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000000);
        far.set_count(6'h05);
        pstrb <= 4'h1;
        apb(1'b1, ATBC_OFF_ICTL, 32'h000003E0);
        pstrb <= 4'hF;
        rd_chk(ATBC_OFF_ICTL, 32'h000000A0);
        sig_irq(1'b0);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000010);
        far.set_count(6'h3F);
        // ---------------------------------
        // Transfer-end and user-data events
        // ---------------------------------
        apb(1'b1, ATBC_OFF_ICTL, 32'h0000000C);
        far.pulse(2'h1);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000000);
        far.pulse(2'h0);
        sig_irq(1'b1);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000008);
        apb(1'b1, ATBC_OFF_ICTL, 32'h0000000C);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000008);
        pstrb <= 4'hB;
        apb(1'b1, ATBC_OFF_ICTL, 32'h0001000C);
        pstrb <= 4'hF;
        rd_chk(ATBC_OFF_ISTAT, 32'h00000008);
        apb(1'b1, ATBC_OFF_ICTL, 32'h0001000C);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000000);
        nonlinear_pcm <= 1'b1;
        far.pulse(2'h0);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000000);
        far.pulse(2'h1);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000008);
        apb(1'b1, ATBC_OFF_ICTL, 32'h0001000C);
        far.pulse(2'h2);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000004);
        sig_irq(1'b1);
        apb(1'b1, ATBC_OFF_ICTL, 32'h0000000C);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000004);
        apb(1'b1, ATBC_OFF_ICTL, 32'h0002000C);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000000);
        sig_irq(1'b0);
        rd_chk(ATBC_OFF_ICTL, 32'h0000000C);
        // Mid-run reset clears control and sticky status
        apb(1'b1, ATBC_OFF_DMA, 32'h0000002A);
        far.pulse(2'h2);
        presetn <= 1'b0;
        idle(2);
        presetn <= 1'b1;
        rd_chk(ATBC_OFF_DMA, 32'h00000000);
        rd_chk(ATBC_OFF_ISTAT, 32'h00000000);
        sig_req(1'b0);
        // Unmapped word: reads zero with an error response
        apb(1'b0, 12'h014, 32'h00000000);
        chk(rv, 32'h00000000);
        chk({31'h0, ev}, 32'h00000001);
        give_verdict();
    end
endmodule
